/* hw/fcev_map.vh */
// Summary of operation
// - code 01 checks every data-flash and program-flash block is erased.
// - code 08 erases all only when both disables and both open bits set.
// - code 09 erases the data-flash block only when its open bit is set.
// - code 0B erases all blocks, verifies them erased, then releases security.
// - code 0D sets the user margin read level for data-flash.
// - code 0E sets the field margin level, special modes only.
// - code 10 checks a count of data-flash words from an address is erased.
// - code 11 programs one to four data-flash words; code 12 erases a sector.
// - program or erase before divider initialized sets access error, command dropped.
// - unrecognized command code sets access error and is not processed.
// - a read of the busy block returns invalid data.
// - such a read sets both fault flags if clear and captures its address.
// - launching a command other than 0D or 0E clears command complete; the flag sets again when done.
// - verify-all and verify-block with index other than 000 set access error.
// - verify-block selects the block from address bits 22:16 in word zero.
// - verify-block with no valid block at those bits sets access error.
// - section verify takes block bits, phrase address, phrase count, index 010.
// - section verify flags bad address or phrase address not 8-byte aligned.
// - section verify flags a range crossing a 256 Kbyte boundary.
// - a command not permitted in the current mode sets access error.
// - verifies never set protection violation; read errors set verify statuses.
// - codes 08 and 0B run only in special modes.
`ifndef FCEV_MAP_VH
`define FCEV_MAP_VH
// ----------------------------------------
// command codes
// ----------------------------------------
`define FCEV_CMD_EV_ALL   8'h01
`define FCEV_CMD_EV_BLK   8'h02
`define FCEV_CMD_EV_PSEC  8'h03
`define FCEV_CMD_ERS_ALL  8'h08
`define FCEV_CMD_ERS_BLK  8'h09
`define FCEV_CMD_UNSEC    8'h0B
`define FCEV_CMD_USR_MRG  8'h0D
`define FCEV_CMD_FLD_MRG  8'h0E
`define FCEV_CMD_EV_DSEC  8'h10
`define FCEV_CMD_PRG_D    8'h11
`define FCEV_CMD_ERS_DSEC 8'h12
// ----------------------------------------
// parameter index values
// ----------------------------------------
`define FCEV_IX_0 3'h0
`define FCEV_IX_1 3'h1
`define FCEV_IX_2 3'h2
`define FCEV_IX_5 3'h5
// ----------------------------------------
// mode permission masks, bit n = mode n
// ----------------------------------------
`define FCEV_MODES_ALL  8'hFF
`define FCEV_MODES_STD  8'h1F
`define FCEV_MODES_SPC  8'hCC
`define FCEV_MODES_FLD  8'h0C
// ----------------------------------------
// array operation codes and constants
// ----------------------------------------
`define FCEV_OP_ERS_ALL 2'h0
`define FCEV_OP_ERS_BLK 2'h1
`define FCEV_OP_ERS_SEC 2'h2
`define FCEV_OP_PRG     2'h3
`define FCEV_ERASED     16'hFFFF
`define FCEV_BLK_LSB    16
`define FCEV_BND_LSB    18
`define FCEV_PHR_SHIFT  3
`endif

/* hw/fcev_seq.v */
`timescale 1ns/1ps
`include "fcev_map.vh"
// ----------------------------------------
// flash command sequencer
// ----------------------------------------
module fcev_seq #(
  parameter [6:0]  PF_BLK_FIRST = 7'h7C,
  parameter [6:0]  PF_BLK_LAST  = 7'h7F,
  parameter [6:0]  DF_BLK       = 7'h10,
  parameter [22:0] PF_WORDS     = 23'h020000,
  parameter [22:0] DF_WORDS     = 23'h004000
) (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        cmd_launch,
  input  wire [7:0]  command_code,
  input  wire [2:0]  param_index,
  input  wire [95:0] command_param_array,
  input  wire        clkdiv_initialized,
  input  wire [2:0]  op_mode,
  input  wire        low_region_protect_disable,
  input  wire        high_region_protect_disable,
  input  wire        pflash_open_bit,
  input  wire        dflash_open_bit,
  input  wire        clear_access_error,
  input  wire        clear_protection_violation,
  input  wire        clear_fault_flags,
  input  wire        rd_req,
  input  wire [22:0] rd_addr,
  input  wire [15:0] arr_rd_data,
  input  wire        arr_rd_err,
  input  wire        arr_rd_uncorr,
  input  wire        arr_op_done,
  input  wire        arr_op_err,
  output wire        arr_rd_en,
  output wire [22:0] arr_rd_addr,
  output reg         arr_op_start_q,
  output reg  [1:0]  arr_op_code_q,
  output reg  [22:0] arr_op_addr_q,
  output reg  [15:0] arr_op_data_q,
  output reg         command_complete_flag,
  output reg         access_error_flag,
  output reg         protection_violation_flag,
  output reg         verify_error_status,
  output reg         uncorrectable_error_status,
  output reg         single_fault_detect_flag,
  output reg         double_fault_detect_flag,
  output reg  [22:0] ecc_cap_addr_q,
  output reg  [15:0] ecc_cap_data_q,
  output reg  [7:0]  ecc_cap_parity_q,
  output reg         rd_invalid_q,
  output reg  [15:0] user_margin_q,
  output reg  [15:0] field_margin_q,
  output reg         unsecured_q
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_OP   = 2'h1;
  localparam [1:0] S_VER  = 2'h2;

  reg [1:0]  state_q;
  reg [7:0]  cmd_q;
  reg        next_pf_q;
  reg        next_df_q;
  reg [1:0]  words_left_q;
  reg [47:0] prog_data_q;
  reg        busy_pf_q;
  reg        busy_df_q;
  reg        v_start_q;
  reg [22:0] v_base_q;
  reg [22:0] v_cnt_q;
  wire       v_done;
  wire       v_fail;
  wire       v_uncorr;

  wire [15:0] w0 = command_param_array[15:0];
  wire [15:0] w1 = command_param_array[31:16];
  wire [15:0] w2 = command_param_array[47:32];
  wire [6:0]  blk = w0[6:0];
  wire [22:0] gaddr = {blk, w1};
  wire [22:0] pf_base = {PF_BLK_FIRST, 16'h0000};
  wire [22:0] df_base = {DF_BLK, 16'h0000};

  function in_pf;
    input [6:0] b;
    begin
      in_pf = (b >= PF_BLK_FIRST) && (b <= PF_BLK_LAST);
    end
  endfunction

  // ----------------------------------------
  // launch checks
  // ----------------------------------------
  reg        known;
  reg [7:0]  modes;
  reg        ix_bad;
  reg        addr_bad;
  reg        prot_bad;
  reg        needs_clk;
  reg [23:0] sec_end;
  reg        acc_err;
  wire       launch_ok;

  always @* begin
    known     = 1'b1;
    modes     = `FCEV_MODES_STD;
    ix_bad    = 1'b0;
    addr_bad  = 1'b0;
    prot_bad  = 1'b0;
    needs_clk = 1'b0;
    sec_end   = {1'b0, gaddr} + {5'h00, w2, 3'h0} - 24'h000001;
    case (command_code)
      `FCEV_CMD_EV_ALL: begin
        modes  = `FCEV_MODES_ALL;
        ix_bad = param_index != `FCEV_IX_0;
      end
      `FCEV_CMD_EV_BLK: begin
        modes    = `FCEV_MODES_ALL;
        ix_bad   = param_index != `FCEV_IX_0;
        addr_bad = !in_pf(blk) && blk != DF_BLK;
      end
      `FCEV_CMD_EV_PSEC: begin
        ix_bad   = param_index != `FCEV_IX_2;
        addr_bad = !in_pf(blk) || gaddr[2:0] != 3'h0 ||
                   (w2 != 16'h0000 && sec_end[23:`FCEV_BND_LSB] != {1'b0, gaddr[22:`FCEV_BND_LSB]});
      end
      `FCEV_CMD_ERS_ALL: begin
        modes     = `FCEV_MODES_SPC;
        needs_clk = 1'b1;
        ix_bad    = param_index != `FCEV_IX_0;
        prot_bad  = !(low_region_protect_disable && high_region_protect_disable &&
                      pflash_open_bit && dflash_open_bit);
      end
      `FCEV_CMD_ERS_BLK: begin
        needs_clk = 1'b1;
        ix_bad    = param_index != `FCEV_IX_1;
        addr_bad  = !in_pf(blk) && blk != DF_BLK;
        prot_bad  = in_pf(blk) ? !(low_region_protect_disable && high_region_protect_disable &&
                                   pflash_open_bit) : !dflash_open_bit;
      end
      `FCEV_CMD_UNSEC: begin
        modes     = `FCEV_MODES_SPC;
        needs_clk = 1'b1;
        ix_bad    = param_index != `FCEV_IX_0;
      end
      `FCEV_CMD_USR_MRG: ix_bad = param_index != `FCEV_IX_1;
      `FCEV_CMD_FLD_MRG: begin
        modes  = `FCEV_MODES_FLD;
        ix_bad = param_index != `FCEV_IX_1;
      end
      `FCEV_CMD_EV_DSEC: begin
        ix_bad   = param_index != `FCEV_IX_2;
        addr_bad = blk != DF_BLK || gaddr[0];
      end
      `FCEV_CMD_PRG_D: begin
        needs_clk = 1'b1;
        ix_bad    = param_index < `FCEV_IX_2 || param_index > `FCEV_IX_5;
        addr_bad  = blk != DF_BLK || gaddr[0];
      end
      `FCEV_CMD_ERS_DSEC: begin
        needs_clk = 1'b1;
        ix_bad    = param_index != `FCEV_IX_1;
        addr_bad  = blk != DF_BLK || gaddr[0];
      end
      default: known = 1'b0;
    endcase
    acc_err = !known || ix_bad || addr_bad || !modes[op_mode] ||
              (needs_clk && !clkdiv_initialized);
  end

  assign launch_ok = cmd_launch && command_complete_flag && state_q == S_IDLE &&
                     !access_error_flag && !protection_violation_flag;
  wire launch_go = launch_ok && !acc_err && !prot_bad;

  // ----------------------------------------
  // collision detect
  // ----------------------------------------
  wire rd_hit = rd_req && !command_complete_flag &&
                ((busy_pf_q && in_pf(rd_addr[22:16])) || (busy_df_q && rd_addr[22:16] == DF_BLK));

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      state_q                    <= S_IDLE;
      cmd_q                      <= 8'h00;
      next_pf_q                  <= 1'b0;
      next_df_q                  <= 1'b0;
      words_left_q               <= 2'h0;
      prog_data_q                <= 48'h000000000000;
      busy_pf_q                  <= 1'b0;
      busy_df_q                  <= 1'b0;
      v_start_q                  <= 1'b0;
      v_base_q                   <= 23'h000000;
      v_cnt_q                    <= 23'h000000;
      arr_op_start_q             <= 1'b0;
      arr_op_code_q              <= 2'h0;
      arr_op_addr_q              <= 23'h000000;
      arr_op_data_q              <= 16'h0000;
      command_complete_flag      <= 1'b1;
      verify_error_status        <= 1'b0;
      uncorrectable_error_status <= 1'b0;
      user_margin_q              <= 16'h0000;
      field_margin_q             <= 16'h0000;
      unsecured_q                <= 1'b0;
    end else begin
      v_start_q      <= 1'b0;
      arr_op_start_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (launch_go) begin
            command_complete_flag      <= 1'b0;
            cmd_q                      <= command_code;
            verify_error_status        <= 1'b0;
            uncorrectable_error_status <= 1'b0;
            next_pf_q                  <= 1'b0;
            next_df_q                  <= 1'b0;
            busy_pf_q                  <= 1'b0;
            busy_df_q                  <= 1'b0;
            state_q                    <= S_VER;
            arr_op_addr_q              <= gaddr;
            case (command_code)
              `FCEV_CMD_EV_ALL: begin
                v_start_q <= 1'b1;
                v_base_q  <= pf_base;
                v_cnt_q   <= PF_WORDS;
                next_df_q <= 1'b1;
                busy_pf_q <= 1'b1;
                busy_df_q <= 1'b1;
              end
              `FCEV_CMD_EV_BLK: begin
                v_start_q <= 1'b1;
                v_base_q  <= in_pf(blk) ? pf_base : df_base;
                v_cnt_q   <= in_pf(blk) ? PF_WORDS : DF_WORDS;
                busy_pf_q <= in_pf(blk);
                busy_df_q <= !in_pf(blk);
              end
              `FCEV_CMD_EV_PSEC: begin
                v_start_q <= 1'b1;
                v_base_q  <= gaddr;
                v_cnt_q   <= {5'h00, w2, 2'h0};
                busy_pf_q <= 1'b1;
              end
              `FCEV_CMD_EV_DSEC: begin
                v_start_q <= 1'b1;
                v_base_q  <= gaddr;
                v_cnt_q   <= {7'h00, w2};
                busy_df_q <= 1'b1;
              end
              `FCEV_CMD_ERS_ALL, `FCEV_CMD_UNSEC: begin
                arr_op_start_q <= 1'b1;
                arr_op_code_q  <= `FCEV_OP_ERS_ALL;
                next_pf_q      <= command_code == `FCEV_CMD_UNSEC;
                busy_pf_q      <= 1'b1;
                busy_df_q      <= 1'b1;
                state_q        <= S_OP;
              end
              `FCEV_CMD_ERS_BLK: begin
                arr_op_start_q <= 1'b1;
                arr_op_code_q  <= `FCEV_OP_ERS_BLK;
                arr_op_addr_q  <= {blk, 16'h0000};
                busy_pf_q      <= in_pf(blk);
                busy_df_q      <= !in_pf(blk);
                state_q        <= S_OP;
              end
              `FCEV_CMD_ERS_DSEC: begin
                arr_op_start_q <= 1'b1;
                arr_op_code_q  <= `FCEV_OP_ERS_SEC;
                busy_df_q      <= 1'b1;
                state_q        <= S_OP;
              end
              `FCEV_CMD_PRG_D: begin
                arr_op_start_q <= 1'b1;
                arr_op_code_q  <= `FCEV_OP_PRG;
                arr_op_data_q  <= w2;
                prog_data_q    <= command_param_array[95:48];
                words_left_q   <= param_index[1:0] - 2'h2;
                busy_df_q      <= 1'b1;
                state_q        <= S_OP;
              end
              `FCEV_CMD_USR_MRG: begin
                user_margin_q         <= w1;
                command_complete_flag <= 1'b1;
                state_q               <= S_IDLE;
              end
              default: begin
                field_margin_q        <= w1;
                command_complete_flag <= 1'b1;
                state_q               <= S_IDLE;
              end
            endcase
          end
        end
        S_OP: begin
          if (arr_op_done) begin
            if (arr_op_err) begin
              verify_error_status   <= 1'b1;
              command_complete_flag <= 1'b1;
              state_q               <= S_IDLE;
            end else if (cmd_q == `FCEV_CMD_PRG_D && words_left_q != 2'h0) begin
              arr_op_start_q <= 1'b1;
              arr_op_addr_q  <= arr_op_addr_q + 23'h000002;
              arr_op_data_q  <= prog_data_q[15:0];
              prog_data_q    <= {16'h0000, prog_data_q[47:16]};
              words_left_q   <= words_left_q - 2'h1;
            end else if (next_pf_q) begin
              v_start_q <= 1'b1;
              v_base_q  <= pf_base;
              v_cnt_q   <= PF_WORDS;
              next_pf_q <= 1'b0;
              next_df_q <= 1'b1;
              state_q   <= S_VER;
            end else begin
              command_complete_flag <= 1'b1;
              state_q               <= S_IDLE;
            end
          end
        end
        S_VER: begin
          if (v_done) begin
            if (v_fail)
              verify_error_status <= 1'b1;
            if (v_uncorr)
              uncorrectable_error_status <= 1'b1;
            if (next_df_q) begin
              v_start_q <= 1'b1;
              v_base_q  <= df_base;
              v_cnt_q   <= DF_WORDS;
              next_df_q <= 1'b0;
            end else begin
              if (cmd_q == `FCEV_CMD_UNSEC && !v_fail && !verify_error_status)
                unsecured_q <= 1'b1;
              command_complete_flag <= 1'b1;
              state_q               <= S_IDLE;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // status flags, set wins over clear
  // ----------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
    end else begin
      if (launch_ok && acc_err)
        access_error_flag <= 1'b1;
      else if (clear_access_error)
        access_error_flag <= 1'b0;
      if (launch_ok && !acc_err && prot_bad)
        protection_violation_flag <= 1'b1;
      else if (clear_protection_violation)
        protection_violation_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // invalid read capture
  // ----------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      single_fault_detect_flag <= 1'b0;
      double_fault_detect_flag <= 1'b0;
      ecc_cap_addr_q           <= 23'h000000;
      ecc_cap_data_q           <= 16'h0000;
      ecc_cap_parity_q         <= 8'h00;
      rd_invalid_q             <= 1'b0;
    end else begin
      rd_invalid_q <= rd_hit;
      if (rd_hit && !single_fault_detect_flag && !double_fault_detect_flag) begin
        single_fault_detect_flag <= 1'b1;
        double_fault_detect_flag <= 1'b1;
        ecc_cap_addr_q           <= rd_addr;
        ecc_cap_data_q           <= 16'h0000;
        ecc_cap_parity_q         <= 8'h00;
      end else if (clear_fault_flags) begin
        single_fault_detect_flag <= 1'b0;
        double_fault_detect_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // erased-state scanner
  // ----------------------------------------
  fcev_verify #(
    .AW (23),
    .DW (16)
  ) u_verify (
    .clock         (clock),
    .sys_rst       (sys_rst),
    .start         (v_start_q),
    .base          (v_base_q),
    .count         (v_cnt_q),
    .arr_rd_data   (arr_rd_data),
    .arr_rd_err    (arr_rd_err),
    .arr_rd_uncorr (arr_rd_uncorr),
    .arr_rd_en_q   (arr_rd_en),
    .arr_rd_addr_q (arr_rd_addr),
    .done_q        (v_done),
    .fail_q        (v_fail),
    .uncorr_q      (v_uncorr)
  );
endmodule

/* hw/fcev_verify.v */
`timescale 1ns/1ps
`include "fcev_map.vh"
// ----------------------------------------
// erased-state scanner over the array read port
// ----------------------------------------
module fcev_verify #(
  parameter AW = 23,
  parameter DW = 16
) (
  input  wire          clock,
  input  wire          sys_rst,
  input  wire          start,
  input  wire [AW-1:0] base,
  input  wire [AW-1:0] count,
  input  wire [DW-1:0] arr_rd_data,
  input  wire          arr_rd_err,
  input  wire          arr_rd_uncorr,
  output reg           arr_rd_en_q,
  output reg  [AW-1:0] arr_rd_addr_q,
  output reg           done_q,
  output reg           fail_q,
  output reg           uncorr_q
);
  reg          busy_q;
  reg [AW-1:0] addr_q;
  reg [AW-1:0] remain_q;

  always @(posedge clock) begin
    if (sys_rst) begin
      busy_q        <= 1'b0;
      addr_q        <= {AW{1'b0}};
      remain_q      <= {AW{1'b0}};
      arr_rd_en_q   <= 1'b0;
      arr_rd_addr_q <= {AW{1'b0}};
      done_q        <= 1'b0;
      fail_q        <= 1'b0;
      uncorr_q      <= 1'b0;
    end else begin
      done_q      <= 1'b0;
      arr_rd_en_q <= 1'b0;
      if (start) begin
        busy_q   <= 1'b1;
        addr_q   <= base;
        remain_q <= count;
        fail_q   <= 1'b0;
        uncorr_q <= 1'b0;
      end else if (busy_q) begin
        if (arr_rd_en_q) begin
          if (arr_rd_data != `FCEV_ERASED || arr_rd_err)
            fail_q <= 1'b1;
          if (arr_rd_uncorr)
            uncorr_q <= 1'b1;
        end
        if (remain_q != {AW{1'b0}}) begin
          arr_rd_en_q   <= 1'b1;
          arr_rd_addr_q <= addr_q;
          addr_q        <= addr_q + {{(AW-2){1'b0}}, 2'h2};
          remain_q      <= remain_q - {{(AW-1){1'b0}}, 1'b1};
        end else if (!arr_rd_en_q) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule

/* verification/fcev_arr_model.sv */
`timescale 1ns/1ps
// ----
// flash array stand-in
// ----
module fcev_arr_model (
  input  wire        clock,
  input  wire        rd_en,
  input  wire [22:0] rd_addr,
  input  wire [22:0] bad_addr,
  input  wire        op_start,
  output reg  [15:0] rd_data,
  output reg         rd_err,
  output reg         rd_uncorr,
  output reg         op_done,
  output reg         op_err
);
  reg [2:0] cnt_q = 3'h0;
  initial {op_done, op_err} = 2'h0;
  // answers in the cycle of the read; idle lines read as programmed
  always @* begin
    rd_data   = (rd_en && rd_addr != bad_addr) ? 16'hFFFF : 16'h0000;
    rd_err    = rd_en && (rd_addr == bad_addr);
    rd_uncorr = rd_en && (rd_addr == bad_addr);
  end
  always @(posedge clock) begin
    op_done   <= (cnt_q == 3'h1);
    op_err    <= 1'b0;
    cnt_q     <= op_start ? 3'h4 : cnt_q - {2'h0, |cnt_q};
  end
endmodule

/* verification/fcev_seq_asserts.sv */
`timescale 1ns/1ps
// ----
// launch and collision checks
// ----
module fcev_seq_chk (
  input wire        clock,
  input wire        sys_rst,
  input wire        cmd_launch,
  input wire [7:0]  command_code,
  input wire [2:0]  param_index,
  input wire        clkdiv_initialized,
  input wire [2:0]  op_mode,
  input wire        pflash_open_bit,
  input wire        rd_req,
  input wire [22:0] rd_addr,
  input wire        command_complete_flag,
  input wire        access_error_flag,
  input wire        protection_violation_flag,
  input wire        single_fault_detect_flag,
  input wire        double_fault_detect_flag,
  input wire [22:0] ecc_cap_addr_q,
  input wire [15:0] ecc_cap_data_q,
  input wire [7:0]  ecc_cap_parity_q,
  input wire        rd_invalid_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire       cc   = command_complete_flag;
  wire       ae   = access_error_flag;
  wire       pv   = protection_violation_flag;
  wire [7:0] cmd  = command_code;
  wire [2:0] ix   = param_index;
  wire       take = cmd_launch && cc && !ae && !pv;
  sequence collide;
    rd_req && !cc && !single_fault_detect_flag && !double_fault_detect_flag ##1 rd_invalid_q;
  endsequence
  a_verify_launch: assert property (take && cmd == 8'h01 && ix == 3'h0 |-> ##[1:2] !cc)
    else $error("verify-all launch left complete set");
  a_index_err: assert property (take && cmd == 8'h01 && ix != 3'h0 |-> ##[1:2] ae)
    else $error("bad index not flagged");
  a_unknown_code: assert property (take && cmd == 8'h05 |-> ##[1:2] ae)
    else $error("unknown code not flagged");
  a_no_divider: assert property (take && cmd == 8'h09 && !clkdiv_initialized |-> ##[1:2] (ae || pv))
    else $error("erase without divider not refused");
  a_special_only: assert property (take && cmd inside {8'h08, 8'h0B, 8'h0E} && !op_mode[1] |-> ##[1:2] ae)
    else $error("special command allowed in normal mode");
  a_erase_prot: assert property (take && cmd == 8'h08 && op_mode[1] && clkdiv_initialized && ix == 3'h0
                                 && !pflash_open_bit |-> ##[1:2] pv)
    else $error("protected erase-all not refused");
  a_verify_nopv: assert property (take && cmd inside {8'h01, 8'h02, 8'h03, 8'h10} |-> ##1 !pv [*2])
    else $error("verify raised protection violation");
  a_err_keeps_cc: assert property ($rose(ae) |-> cc && $past(cc))
    else $error("error flag raised with complete low");
  a_collide_cap: assert property (collide |-> single_fault_detect_flag && double_fault_detect_flag
    && ecc_cap_addr_q == $past(rd_addr) && ecc_cap_data_q == 16'h0000 && ecc_cap_parity_q == 8'h00)
    else $error("collision capture wrong");
  a_invalid_cause: assert property (rd_invalid_q |-> $past(rd_req) && !$past(cc))
    else $error("invalid read flagged without collision");
endmodule
bind fcev_seq fcev_seq_chk u_chk (.*);

/* verification/tb.sv */
`timescale 1ns/1ps
// ----
// sequencer bench
// ----
module tb;
  reg         clock = 1'b0;
  reg         sys_rst = 1'b1;
  reg         go = 1'b0;
  reg  [7:0]  code = 8'h00;
  reg  [2:0]  idx = 3'h0;
  reg  [95:0] prm = 96'h0;
  reg         div = 1'b1;
  reg  [2:0]  mode = 3'h0;
  reg  [3:0]  prot = 4'hF;
  reg  [2:0]  clr = 3'h0;
  reg         rdq = 1'b0;
  reg  [22:0] rda = 23'h000000;
  reg  [22:0] bad = 23'h7FFFFF;
  integer     fails = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  wire        ren, ost, rerr, runc, odone, oerr, cc, ae, pv, ves, ues, sfd, dfd, rinv, unsec;
  wire [22:0] radr, cap, oad;
  wire [15:0] rdat, odat, umg, fmg;
  wire [1:0]  ocode;
  fcev_seq #(.PF_WORDS(23'h000010), .DF_WORDS(23'h000008)) dut (
    .clock(clock), .sys_rst(sys_rst), .cmd_launch(go), .command_code(code), .param_index(idx),
    .command_param_array(prm), .clkdiv_initialized(div), .op_mode(mode),
    .low_region_protect_disable(prot[0]), .high_region_protect_disable(prot[1]),
    .pflash_open_bit(prot[2]), .dflash_open_bit(prot[3]), .clear_access_error(clr[0]),
    .clear_protection_violation(clr[1]), .clear_fault_flags(clr[2]), .rd_req(rdq), .rd_addr(rda),
    .arr_rd_data(rdat), .arr_rd_err(rerr), .arr_rd_uncorr(runc), .arr_op_done(odone), .arr_op_err(oerr),
    .arr_rd_en(ren), .arr_rd_addr(radr), .arr_op_start_q(ost), .arr_op_code_q(ocode), .arr_op_addr_q(oad),
    .arr_op_data_q(odat), .command_complete_flag(cc), .access_error_flag(ae), .protection_violation_flag(pv),
    .verify_error_status(ves), .uncorrectable_error_status(ues), .single_fault_detect_flag(sfd),
    .double_fault_detect_flag(dfd), .ecc_cap_addr_q(cap), .ecc_cap_data_q(), .ecc_cap_parity_q(),
    .rd_invalid_q(rinv), .user_margin_q(umg), .field_margin_q(fmg), .unsecured_q(unsec));
  fcev_arr_model arr (.clock(clock), .rd_en(ren), .rd_addr(radr), .bad_addr(bad), .op_start(ost),
    .rd_data(rdat), .rd_err(rerr), .rd_uncorr(runc), .op_done(odone), .op_err(oerr));
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      give_verdict;
    end
  end
  task chk(input [95:0] nm, input [22:0] e, input [22:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("[FAIL] %0s exp %h got %h", nm, e, g);
    end
  endtask
  task send(input [7:0] c, input [2:0] i, input [95:0] w);
    @(negedge clock) {go, code, idx, prm} = {1'b1, c, i, w};
    @(negedge clock) go = 1'b0;
    @(negedge clock);
  endtask
  task clear;
    @(negedge clock) clr = 3'h7;
    @(negedge clock) clr = 3'h0;
  endtask
  task wait_cc;
    for (int i = 0; i < 600 && cc !== 1'b1; i++) @(negedge clock);
    chk("complete", 1, cc);
  endtask
  task give_verdict;
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task t_vall;
    send(8'h01, 3'h0, 96'h0);
    chk("busy", 0, cc);
    @(negedge clock) {rdq, rda} = {1'b1, 23'h7C0010};
    @(negedge clock) rdq = 1'b0;
    chk("invalid", 1, rinv);
    chk("faults", 3, {sfd, dfd});
    chk("cap", 23'h7C0010, cap);
    wait_cc;
    chk("verr", 0, ves);
  endtask
  task t_vblk;
    bad = 23'h100006;
    send(8'h02, 3'h0, 96'h10);
    wait_cc;
    chk("verr", 3, {ves, ues});
    chk("pviol", 0, pv);
    send(8'h10, 3'h2, 96'h0003_0000_0010);
    wait_cc;
    chk("sec3", 0, ves);
    send(8'h10, 3'h2, 96'h0004_0000_0010);
    wait_cc;
    chk("sec4", 1, ves);
    bad = 23'h7C0006;
    send(8'h03, 3'h2, 96'h0001_0000_007C);
    wait_cc;
    chk("psec", 1, ves);
    bad = 23'h7FFFFF;
  endtask
  task t_err;
    for (int n = 0; n < 8; n++) begin
      {mode, div} = {3'h0, n != 7};
      case (n)
        0: send(8'h01, 3'h1, 96'h0);
        1: send(8'h02, 3'h0, 96'h0);
        2: send(8'h05, 3'h0, 96'h0);
        3: send(8'h0E, 3'h1, 96'h0);
        4: send(8'h08, 3'h0, 96'h0);
        5: send(8'h03, 3'h2, 96'h0001_0004_007C);
        6: send(8'h03, 3'h2, 96'h0002_FFF8_007F);
        default: send(8'h09, 3'h1, 96'h10);
      endcase
      chk("access_error_flag", 3, {ae, cc});
      send(8'h01, 3'h0, 96'h0);
      chk("ignored", 1, cc);
      clear;
    end
    div = 1'b1;
  endtask
  task t_ers;
    mode = 3'h2;
    send(8'h08, 3'h0, 96'h0);
    chk("ersall", 0, {cc, ocode});
    wait_cc;
    prot = 4'hB;
    send(8'h08, 3'h0, 96'h0);
    chk("prot", 3, {pv, cc});
    clear;
    prot = 4'h7;
    send(8'h09, 3'h1, 96'h10);
    chk("dprot", 3, {pv, cc});
    clear;
    prot = 4'hF;
    send(8'h09, 3'h1, 96'h10);
    chk("ersblk", 1, {cc, ocode});
    wait_cc;
  endtask
  task t_uns;
    send(8'h0B, 3'h0, 96'h0);
    wait_cc;
    chk("unsec", 1, unsec);
  endtask
  task t_mrg;
    send(8'h0E, 3'h1, 96'hABCD_0000);
    chk("field", 16'hABCD, fmg);
    mode = 3'h0;
    send(8'h0D, 3'h1, 96'h1234_0000);
    chk("user", 16'h1234, umg);
  endtask
  task t_prg;
    send(8'h11, 3'h3, 96'h5A5A_A5A5_0000_0010);
    chk("prg1", 23'h3A5A5, {ocode, odat});
    wait_cc;
    chk("prg2", 23'h35A5A, {ocode, odat});
    chk("prgadr", 23'h100002, oad);
    send(8'h12, 3'h1, 96'h10);
    chk("ersec", 2, ocode);
    wait_cc;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock) sys_rst = 1'b0;
    chk("rst", 1, {ae, cc});
    t_vall;
    t_vblk;
    t_err;
    t_ers;
    t_uns;
    t_mrg;
    t_prg;
    give_verdict;
  end
endmodule
